// ===== pkg/mpei_defines.svh
// constants for the motor power enable interlock
`ifndef MPEI_DEFINES_SVH
`define MPEI_DEFINES_SVH

// system clock rate in hertz (50 MHz)
`define MPEI_CLK_HZ        32'h02faf080
// confirmation window after reset, in seconds, and its enable
`define MPEI_WIN_SEC_RST   8'h0a
`define MPEI_TMO_EN_RST    1'b1
// indicator flash half period in milliseconds, and its cycle count
`define MPEI_FLASH_HALF_MS 32'h000000fa
`define MPEI_FLASH_CYC     ((`MPEI_CLK_HZ / 32'h000003e8) * `MPEI_FLASH_HALF_MS)
// manual mode speed cap in mm/s
`define MPEI_SPEED_MANUAL  16'h00fa
// selector switch levels
`define MPEI_SW2_OPERATION 1'b1
`define MPEI_SW1_RESERVED  1'b1

`endif

// ===== pkg/mpei_pkg.sv
// types shared by the motor power enable interlock
package mpei_pkg;
   typedef enum logic [1:0] {
      st_idle = 2'b00,
      st_pend = 2'b01,
      st_on   = 2'b10
   } mpei_state_t;
endpackage

// ===== verilog/mpei_window_timer.sv
// confirmation window timer and indicator flash generator
`timescale 1ns/1ps
`default_nettype none
`include "mpei_defines.svh"

module mpei_window_timer #(
   parameter logic [31:0] CYC_PER_SEC = `MPEI_CLK_HZ,
   parameter logic [31:0] FLASH_CYC   = `MPEI_FLASH_CYC
) (
   input  wire logic       sys_clk,  // system clock
   input  wire logic       rst_b,    // async reset, low
   input  wire logic       start,    // load window and run
   input  wire logic       cancel,   // stop without expiry
   input  wire logic [7:0] win_sec,  // window length, seconds
   output logic            expired,  // one-cycle expiry pulse
   output logic            flash     // square wave while running
);

   logic        running;
   logic [31:0] pre_cnt;
   logic [7:0]  sec_cnt;
   logic [31:0] fl_cnt;
   logic        next_running;
   logic [31:0] next_pre_cnt;
   logic [7:0]  next_sec_cnt;
   logic [31:0] next_fl_cnt;
   logic        next_flash;
   logic        next_expired;
   logic        sec_tick;

   // one second prescale, then whole seconds count down
   always_comb begin
      next_running = running;
      next_pre_cnt = pre_cnt;
      next_sec_cnt = sec_cnt;
      next_fl_cnt  = fl_cnt;
      next_flash   = flash;
      next_expired = 1'b0;
      sec_tick     = (pre_cnt == CYC_PER_SEC - 32'h1);
      if (start) begin
         next_running = 1'b1;
         next_pre_cnt = 32'h0;
         next_sec_cnt = win_sec;
         next_fl_cnt  = 32'h0;
         next_flash   = 1'b1;
      end else if (cancel) begin
         next_running = 1'b0;
         next_flash   = 1'b0;
      end else if (running) begin
         // a zero-length window expires on the first running cycle
         if (sec_cnt == 8'h0 || (sec_tick && sec_cnt == 8'h1)) begin
            next_running = 1'b0;
            next_flash   = 1'b0;
            next_expired = 1'b1;
         end else begin
            next_pre_cnt = sec_tick ? 32'h0 : pre_cnt + 32'h1;
            if (sec_tick) begin
               next_sec_cnt = sec_cnt - 8'h1;
            end
            if (fl_cnt == FLASH_CYC - 32'h1) begin
               next_fl_cnt = 32'h0;
               next_flash  = ~flash;
            end else begin
               next_fl_cnt = fl_cnt + 32'h1;
            end
         end
      end
   end

   // registers only
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         running <= 1'b0;
         pre_cnt <= 32'h0;
         sec_cnt <= 8'h0;
         fl_cnt  <= 32'h0;
         flash   <= 1'b0;
         expired <= 1'b0;
      end else begin
         running <= next_running;
         pre_cnt <= next_pre_cnt;
         sec_cnt <= next_sec_cnt;
         fl_cnt  <= next_fl_cnt;
         flash   <= next_flash;
         expired <= next_expired;
      end
   end

endmodule // mpei_window_timer

`default_nettype wire

// ===== verilog/mpei_interlock.sv
// motor power enable interlock: modes, safety gating, confirmation, brake
//
// Contract
// - a change of the manual/automatic key switch forces motor power off at once.
// - the operation/service selector is sampled once after reset and then held.
// - selector 2 in the operation position gives operation mode, else service mode.
// - selector 1 picks the standard host setting; its reserved position enables nothing.
// - motor power is refused unless every safety circuit input is satisfied.
// - the brake is released exactly while motor power is on and engaged otherwise.
// - with the timeout on, a request opens a flashing window that needs a button press.
// - after reset the timeout is on with a ten second window, both configurable.
// - in manual mode commanded speed is capped at 250 mm/s and torque is restricted.
// - in manual mode motion comes only from the pendant and programs only single-step.
// - program and I/O control run with power off; only motion requests stall.
// - power on energizes every servo motor together and power off drops them all.
// - while a fault is present motor power cannot be turned on.
// - a fault or an open emergency-stop circuit turns motor power off.
// - a panel button press while power is on turns motor power off.
`timescale 1ns/1ps
`default_nettype none
`include "mpei_defines.svh"

module mpei_interlock #(
   parameter int          N_SAFETY    = 4,
   parameter int          N_MOTOR     = 4,
   parameter logic [31:0] CYC_PER_SEC = `MPEI_CLK_HZ,
   parameter logic [31:0] FLASH_CYC   = `MPEI_FLASH_CYC
) (
   input  wire logic                sys_clk,        // system clock, 50 MHz
   input  wire logic                rst_b,          // async reset, low
   input  wire logic                key_auto,       // key switch: 1 auto, 0 manual
   input  wire logic                dip_mode_sw,    // selector 2, 1 = operation
   input  wire logic                dip_host_sw,    // selector 1, 1 = reserved
   input  wire logic [N_SAFETY-1:0] safety_ok,      // 1 = circuit satisfied
   input  wire logic                estop_closed,   // 1 = e-stop loop closed
   input  wire logic                fault,          // 1 = fault present
   input  wire logic                power_req,      // power-on request pulse
   input  wire logic                power_off_req,  // power-off request pulse
   input  wire logic                panel_button,   // panel button press pulse
   input  wire logic                cfg_wr,         // load timeout settings
   input  wire logic                cfg_tmo_en,     // timeout enable to load
   input  wire logic [7:0]          cfg_win_sec,    // window seconds to load
   input  wire logic                net_motion_req, // motion from network
   input  wire logic                pnd_motion_req, // motion from pendant
   input  wire logic [15:0]         cmd_speed,      // commanded speed, mm/s
   input  wire logic                prog_run_req,   // continuous program step
   input  wire logic                prog_step_req,  // single program step
   output logic                     motor_power_on, // power contactor on
   output logic                     brake_release,  // 1 = brake released
   output logic [N_MOTOR-1:0]       motor_enable,   // per servo enable
   output logic                     indicator,      // panel lamp
   output logic                     timeout_event,  // window expired pulse
   output logic                     tmo_en,         // timeout enabled
   output logic [7:0]               win_sec,        // window seconds
   output logic                     op_mode,        // operation mode
   output logic                     service_mode,   // service mode
   output logic                     host_standard,  // standard host setting
   output logic                     host_reserved,  // reserved position seen
   output logic                     manual_mode,    // manual mode
   output logic                     torque_limit,   // torque restricted
   output logic [15:0]              speed_out,      // capped speed
   output logic                     motion_accept,  // motion request taken
   output logic                     motion_stall,   // motion held, power off
   output logic                     prog_advance,   // program may step
   output logic                     step_only       // single-step execution
);

   mpei_pkg::mpei_state_t state;
   mpei_pkg::mpei_state_t next_state;

   logic strap_done;
   logic key_prev;
   logic key_change;
   logic kill;
   logic permit;
   logic win_start;
   logic win_cancel;
   logic win_expired;
   logic win_flash;
   logic next_strap_done;
   logic next_op_mode;
   logic next_host_reserved;
   logic next_power;
   logic next_indicator;
   logic next_timeout;
   logic next_tmo_en;
   logic [7:0] next_win_sec;
   logic next_manual;
   logic [15:0] next_speed;
   logic next_accept;
   logic next_stall;
   logic next_advance;
   logic motion_req;

   // straps: taken on the first edge after release, never again
   always_comb begin
      next_strap_done    = 1'b1;
      next_op_mode       = op_mode;
      next_host_reserved = host_reserved;
      if (!strap_done) begin
         next_op_mode       = (dip_mode_sw == `MPEI_SW2_OPERATION);
         next_host_reserved = (dip_host_sw == `MPEI_SW1_RESERVED);
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         strap_done    <= 1'b0;
         op_mode       <= 1'b0;
         host_reserved <= 1'b0;
      end else begin
         strap_done    <= next_strap_done;
         op_mode       <= next_op_mode;
         host_reserved <= next_host_reserved;
      end
   end

   // both modes stay low until the straps are in
   assign service_mode  = strap_done & ~op_mode;
   // reserved position only drops the standard flag, nothing is unlocked
   assign host_standard = strap_done & ~host_reserved;

   // timeout settings, reset to enabled and ten seconds
   always_comb begin
      next_tmo_en  = tmo_en;
      next_win_sec = win_sec;
      if (cfg_wr) begin
         next_tmo_en  = cfg_tmo_en;
         next_win_sec = cfg_win_sec;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         tmo_en  <= `MPEI_TMO_EN_RST;
         win_sec <= `MPEI_WIN_SEC_RST;
      end else begin
         tmo_en  <= next_tmo_en;
         win_sec <= next_win_sec;
      end
   end

   // key edge; ignored until straps are in so reset does not fake one
   assign key_change = strap_done & (key_auto != key_prev);
   assign kill   = key_change | fault | ~estop_closed;
   // permit needs every safety input and no fault in this very cycle
   assign permit = strap_done & (&safety_ok) & ~kill;

   // power sequencer: idle, pending confirmation, on
   always_comb begin
      next_state   = state;
      next_timeout = 1'b0;
      win_start    = 1'b0;
      unique case (state)
         mpei_pkg::st_idle: begin
            if ((power_req || panel_button) && !kill) begin
               if (tmo_en) begin
                  next_state = mpei_pkg::st_pend;
                  win_start  = 1'b1;
               end else if (permit) begin
                  next_state = mpei_pkg::st_on;
               end
            end
         end
         mpei_pkg::st_pend: begin
            // a press in the expiry cycle still counts
            if (kill || power_off_req) begin
               next_state = mpei_pkg::st_idle;
            end else if (panel_button && permit) begin
               next_state = mpei_pkg::st_on;
            end else if (win_expired) begin
               next_state   = mpei_pkg::st_idle;
               next_timeout = 1'b1;
            end
         end
         mpei_pkg::st_on: begin
            if (kill || panel_button || power_off_req) begin
               next_state = mpei_pkg::st_idle;
            end
         end
         default: begin
            next_state = mpei_pkg::st_idle;
         end
      endcase
      win_cancel = (state == mpei_pkg::st_pend) && (next_state != mpei_pkg::st_pend);
      next_power = (next_state == mpei_pkg::st_on);
      // lamp solid when on, flashing while the window runs
      if (next_state == mpei_pkg::st_on) begin
         next_indicator = 1'b1;
      end else if (next_state == mpei_pkg::st_pend) begin
         next_indicator = win_start | win_flash;
      end else begin
         next_indicator = 1'b0;
      end
   end

   // brake and all servo enables share one next value, so they never skew
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         state          <= mpei_pkg::st_idle;
         key_prev       <= 1'b0;
         motor_power_on <= 1'b0;
         brake_release  <= 1'b0;
         motor_enable   <= '0;
         indicator      <= 1'b0;
         timeout_event  <= 1'b0;
      end else begin
         state          <= next_state;
         key_prev       <= key_auto;
         motor_power_on <= next_power;
         brake_release  <= next_power;
         motor_enable   <= {N_MOTOR{next_power}};
         indicator      <= next_indicator;
         timeout_event  <= next_timeout;
      end
   end

   // window timing on the system clock
   mpei_window_timer #(
      .CYC_PER_SEC (CYC_PER_SEC),
      .FLASH_CYC   (FLASH_CYC)
   ) u_timer (
      .sys_clk (sys_clk),
      .rst_b   (rst_b),
      .start   (win_start),
      .cancel  (win_cancel),
      .win_sec (win_sec),
      .expired (win_expired),
      .flash   (win_flash)
   );

   // motion and program gating; program stepping never looks at power
   always_comb begin
      next_manual  = ~key_auto;
      // pendant only in manual, either source in automatic
      motion_req   = pnd_motion_req | (key_auto & net_motion_req);
      next_accept  = motion_req & motor_power_on;
      next_stall   = motion_req & ~motor_power_on;
      next_advance = key_auto ? (prog_run_req | prog_step_req)
                              : prog_step_req;
      next_speed   = cmd_speed;
      if (!key_auto && cmd_speed > `MPEI_SPEED_MANUAL) begin
         next_speed = `MPEI_SPEED_MANUAL;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         manual_mode   <= 1'b0;
         speed_out     <= 16'h0;
         motion_accept <= 1'b0;
         motion_stall  <= 1'b0;
         prog_advance  <= 1'b0;
      end else begin
         manual_mode   <= next_manual;
         speed_out     <= next_speed;
         motion_accept <= next_accept;
         motion_stall  <= next_stall;
         prog_advance  <= next_advance;
      end
   end

   assign torque_limit = manual_mode;
   assign step_only    = manual_mode;

   // checks
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_b);

   chk_key_drop: assert property (
      strap_done && key_auto != key_prev |=> !motor_power_on
   ) else $error("key change left motor power on");

   chk_strap_hold: assert property (
      strap_done && $past(strap_done) |-> $stable(op_mode) && $stable(host_reserved)
   ) else $error("mode strap changed after power-up");

   chk_mode_excl: assert property (
      $rose(strap_done) |-> op_mode == $past(dip_mode_sw == `MPEI_SW2_OPERATION)
                            && op_mode != service_mode
   ) else $error("operation and service mode not exclusive");

   chk_host_flag: assert property (
      $rose(strap_done) |-> host_reserved == $past(dip_host_sw == `MPEI_SW1_RESERVED)
                            && host_standard != host_reserved
   ) else $error("host setting flags inconsistent");

   chk_safety_gate: assert property (
      $rose(motor_power_on) |-> $past(&safety_ok) && !$past(fault) && $past(estop_closed)
   ) else $error("power on without safety or with fault");

   chk_brake_track: assert property (
      brake_release == motor_power_on && motor_enable == {N_MOTOR{motor_power_on}}
   ) else $error("brake or servo enable out of step with power");

   chk_window_need: assert property (
      $rose(motor_power_on) && tmo_en && $past(tmo_en) |-> $past(panel_button)
   ) else $error("power on without confirmation press");

   chk_timeout_off: assert property (
      timeout_event |-> !motor_power_on && !indicator
   ) else $error("timeout left power or lamp on");

   chk_fault_drop: assert property (
      fault || !estop_closed |=> !motor_power_on
   ) else $error("fault or open e-stop left power on");

   chk_button_off: assert property (
      motor_power_on && panel_button |=> !motor_power_on
   ) else $error("panel press while on did not drop power");

   chk_speed_cap: assert property (
      $past(!key_auto) |-> speed_out <= `MPEI_SPEED_MANUAL
   ) else $error("manual speed above cap");

   chk_pend_only: assert property (
      !key_auto && !pnd_motion_req && motor_power_on |=> !motion_accept
   ) else $error("manual mode took network motion");

endmodule // mpei_interlock

`default_nettype wire

// ===== testbench/mpei_panel_model.sv
// operator panel, key switch and pendant model for the interlock bench
`timescale 1ns/1ps
`default_nettype none

module mpei_panel_model (
   input  wire logic sys_clk,        // system clock
   output logic      key_auto,       // key switch, 1 auto
   output logic      panel_button,   // one-cycle button press
   output logic      pnd_motion_req  // pendant jog request
);
   // operator starts in auto, hands off the controls
   initial begin
      key_auto = 1'b1;
      panel_button = 1'b0;
      pnd_motion_req = 1'b0;
   end

   // press after a hold-off; one cycle wide, as a debounced button gives it
   task automatic press(input int wait_cyc);
      repeat (wait_cyc) @(negedge sys_clk);
      @(negedge sys_clk);
      panel_button = 1'b1;
      @(negedge sys_clk);
      panel_button = 1'b0;
   endtask

   // key turns are plain levels, no bounce modelled
   task automatic set_key(input logic v);
      @(negedge sys_clk);
      key_auto = v;
   endtask

   task automatic jog(input logic v);
      @(negedge sys_clk);
      pnd_motion_req = v;
   endtask
endmodule // mpei_panel_model
`default_nettype wire

// ===== testbench/tb_motor_power_enable_interlock.sv
// self-checking bench for the motor power enable interlock
`timescale 1ns/1ps
`default_nettype none
`include "mpei_defines.svh"

module tb_motor_power_enable_interlock;
   logic        sys_clk, rst_b, key_auto, dip_mode_sw, dip_host_sw, estop_closed, fault;
   logic        power_req, power_off_req, panel_button, cfg_wr, cfg_tmo_en;
   logic        net_motion_req, pnd_motion_req, prog_run_req, prog_step_req;
   logic [3:0]  safety_ok, motor_enable;
   logic [7:0]  cfg_win_sec, win_sec;
   logic [15:0] cmd_speed, speed_out;
   logic        motor_power_on, brake_release, indicator, timeout_event, tmo_en, op_mode;
   logic        service_mode, host_standard, host_reserved, manual_mode, torque_limit;
   logic        motion_accept, motion_stall, prog_advance, step_only;
   int          mismatches = 0;
   int          check_count = 0;

   // short counts keep the ten second window at 100 cycles
   mpei_interlock #(.CYC_PER_SEC(32'h0000000a), .FLASH_CYC(32'h00000002)) DUT (
      .sys_clk(sys_clk), .rst_b(rst_b), .key_auto(key_auto), .dip_mode_sw(dip_mode_sw),
      .dip_host_sw(dip_host_sw), .safety_ok(safety_ok), .estop_closed(estop_closed),
      .fault(fault), .power_req(power_req), .power_off_req(power_off_req),
      .panel_button(panel_button), .cfg_wr(cfg_wr), .cfg_tmo_en(cfg_tmo_en),
      .cfg_win_sec(cfg_win_sec), .net_motion_req(net_motion_req),
      .pnd_motion_req(pnd_motion_req), .cmd_speed(cmd_speed), .prog_run_req(prog_run_req),
      .prog_step_req(prog_step_req), .motor_power_on(motor_power_on),
      .brake_release(brake_release), .motor_enable(motor_enable), .indicator(indicator),
      .timeout_event(timeout_event), .tmo_en(tmo_en), .win_sec(win_sec), .op_mode(op_mode),
      .service_mode(service_mode), .host_standard(host_standard),
      .host_reserved(host_reserved), .manual_mode(manual_mode), .torque_limit(torque_limit),
      .speed_out(speed_out), .motion_accept(motion_accept), .motion_stall(motion_stall),
      .prog_advance(prog_advance), .step_only(step_only));

   mpei_panel_model u_panel (.sys_clk(sys_clk), .key_auto(key_auto),
      .panel_button(panel_button), .pnd_motion_req(pnd_motion_req));

   // 50 MHz system clock
   initial sys_clk = 1'b0;
   always #10 sys_clk = ~sys_clk;

   task automatic tick(input int n);
      repeat (n) @(negedge sys_clk);
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d, mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // one-cycle request pulse; returns once the sampling edge has landed
   task automatic pulse(input logic off);
      @(negedge sys_clk);
      power_off_req = off;
      power_req = ~off;
      @(negedge sys_clk);
      power_off_req = 1'b0;
      power_req = 1'b0;
   endtask

   // safety inputs move together so a scenario sets one whole picture at a time
   task automatic set_safety(input logic [3:0] ok, input logic flt, input logic closed);
      safety_ok = ok;
      fault = flt;
      estop_closed = closed;
   endtask

   task automatic set_motion(input logic net, input logic run, input logic step,
                             input logic [15:0] spd);
      net_motion_req = net;
      prog_run_req = run;
      prog_step_req = step;
      cmd_speed = spd;
   endtask

   task automatic cfg(input logic en, input logic [7:0] sec);
      @(negedge sys_clk);
      cfg_wr = 1'b1;
      cfg_tmo_en = en;
      cfg_win_sec = sec;
      @(negedge sys_clk);
      cfg_wr = 1'b0;
      check("tmo_en", tmo_en, en);
      check("win_sec", win_sec, sec);
   endtask

   // reset with given straps, then move the switches and expect them ignored
   task automatic do_reset(input logic mode_sw, input logic host_sw);
      rst_b = 1'b0;
      dip_mode_sw = mode_sw;
      dip_host_sw = host_sw;
      tick(16);
      check("reset power", motor_power_on, 0);
      check("reset brake", brake_release, 0);
      check("reset indicator", indicator, 0);
      check("reset tmo_en", tmo_en, `MPEI_TMO_EN_RST);
      check("reset win_sec", win_sec, `MPEI_WIN_SEC_RST);
      rst_b = 1'b1;
      tick(2);
      check("op_mode", op_mode, mode_sw == `MPEI_SW2_OPERATION);
      check("service_mode", service_mode, mode_sw != `MPEI_SW2_OPERATION);
      check("host_standard", host_standard, host_sw != `MPEI_SW1_RESERVED);
      check("host_reserved", host_reserved, host_sw == `MPEI_SW1_RESERVED);
      dip_mode_sw = ~mode_sw;
      dip_host_sw = ~host_sw;
      tick(3);
      check("op_mode held", op_mode, mode_sw == `MPEI_SW2_OPERATION);
      check("host held", host_reserved, host_sw == `MPEI_SW1_RESERVED);
   endtask

   task automatic s_confirm();
      pulse(1'b0);
      check("indicator pending", indicator, 1);
      check("power pending", motor_power_on, 0);
      u_panel.press(5);
      check("power on", motor_power_on, 1);
      check("brake on", brake_release, 1);
      check("motors on", motor_enable, 4'hf);
      u_panel.press(0);
      check("power off", motor_power_on, 0);
      check("brake off", brake_release, 0);
      check("motors off", motor_enable, 4'h0);
   endtask

   // unanswered request: count cycles to expiry, watch the lamp flash
   task automatic s_timeout(input int secs);
      int   n = 0;
      logic lo = 1'b0;
      pulse(1'b0);
      while (timeout_event !== 1'b1 && n < 400) begin
         if (indicator === 1'b0) lo = 1'b1;
         tick(1);
         n++;
      end
      check("indicator flash", lo, 1);
      check("window", n >= secs * 10 - 2 && n <= secs * 10 + 3, 1);
      tick(1);
      check("power after expiry", motor_power_on, 0);
      check("indicator after expiry", indicator, 0);
   endtask

   // timeout off: each open safety input or a fault refuses, then each kill or an off request drops power
   task automatic s_refuse_kill();
      cfg(1'b0, 8'h0a);
      for (int i = 0; i < 5; i++) begin
         if (i < 4) begin
            set_safety(~(4'h1 << i), 1'b0, 1'b1);
         end else begin
            set_safety(4'hf, 1'b1, 1'b1);
         end
         pulse(1'b0);
         tick(1);
         check("power refused", motor_power_on, 0);
         set_safety(4'hf, 1'b0, 1'b1);
      end
      for (int k = 0; k < 4; k++) begin
         tick(3);
         pulse(1'b0);
         check("power permitted", motor_power_on, 1);
         case (k)
            0: set_safety(4'hf, 1'b1, 1'b1);
            1: set_safety(4'hf, 1'b0, 1'b0);
            2: u_panel.set_key(1'b0);
            default: pulse(1'b1);
         endcase
         tick(3);
         check("power killed", motor_power_on, 0);
         check("brake engaged", brake_release, 0);
         set_safety(4'hf, 1'b0, 1'b1);
         if (k == 2) u_panel.set_key(1'b1);
      end
      tick(3);
   endtask

   task automatic s_motion();
      u_panel.set_key(1'b0);
      tick(3);
      pulse(1'b0);
      set_motion(1'b1, 1'b1, 1'b0, 16'h03e8);
      tick(2);
      check("manual power", motor_power_on, 1);
      check("manual_mode", manual_mode, 1);
      check("torque_limit", torque_limit, 1);
      check("speed cap", speed_out, `MPEI_SPEED_MANUAL);
      check("network refused", motion_accept, 0);
      check("run refused", prog_advance, 0);
      check("step_only", step_only, 1);
      set_motion(1'b0, 1'b0, 1'b1, 16'h03e8);
      u_panel.jog(1'b1);
      tick(2);
      check("pendant taken", motion_accept, 1);
      check("step taken", prog_advance, 1);
      pulse(1'b1);
      tick(2);
      check("motion stall", motion_stall, 1);
      check("motion held", motion_accept, 0);
      check("program unpowered", prog_advance, 1);
      u_panel.jog(1'b0);
      u_panel.set_key(1'b1);
      set_motion(1'b1, 1'b0, 1'b1, 16'h03e8);
      tick(3);
      check("speed uncapped", speed_out, 16'h03e8);
      check("torque free", torque_limit, 0);
      pulse(1'b0);
      tick(1);
      check("network taken", motion_accept, 1);
      pulse(1'b1);
      set_motion(1'b0, 1'b0, 1'b0, 16'h03e8);
      tick(2);
   endtask

   // all inputs at rest before the first edge; reset with operation straps
   initial begin
      {power_req, power_off_req, cfg_wr, cfg_tmo_en} = 4'h0;
      set_safety(4'hf, 1'b0, 1'b1);
      set_motion(1'b0, 1'b0, 1'b0, 16'h0000);
      cfg_win_sec = 8'h00;
      do_reset(1'b1, 1'b0);
      s_confirm();
      s_timeout(10);
      s_refuse_kill();
      s_motion();
      cfg(1'b1, 8'h02);
      s_timeout(2);
      do_reset(1'b0, 1'b1);
      s_confirm();
      complete_run();
   end

   // the tests need about 300 cycles; over fifteen times that means a hang
   initial begin
      repeat (5000) @(posedge sys_clk);
      mismatches++;
      complete_run();
   end
endmodule // tb_motor_power_enable_interlock
`default_nettype wire
